// [core/lamc_pkg.sv]
// Constants and types for the auto-mode link control block
package lamc_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0] REG_MODE = 8'h00;
    localparam logic [7:0] REG_TIMER = 8'h04;
    localparam logic [7:0] REG_CMD = 8'h08;
    localparam logic [7:0] REG_MAIN_STATUS = 8'h0C;
    localparam logic [7:0] REG_AUTO_STATUS = 8'h10;

    // Mode register fields
    localparam int MODE_AUTO_BIT = 0;
    localparam int MODE_TMD_BIT = 1;
    // Command register fields
    localparam int CMD_NUMBERED_BIT = 0;
    localparam int CMD_TRANSPARENT_BIT = 1;
    localparam int CMD_START_TIMER_BIT = 2;
    localparam int CMD_RX_RESET_BIT = 3;
    localparam int CMD_TX_RESET_BIT = 4;
    // Timer register fields
    localparam int TIMER_T200_LSB = 0;
    localparam int TIMER_N2_LSB = 8;
    // Main status fields
    localparam int MAIN_PEER_BUSY_BIT = 0;
    localparam int MAIN_POOL_FREE_BIT = 1;
    // Auto status fields
    localparam int AUTO_RECOVERY_BIT = 0;
    localparam int AUTO_WFA_BIT = 1;
    localparam int AUTO_SUPERVISORY_SEEN_FLAG_BIT = 2;

    // ------------------------------------------------------------------
    // Reset values, timing and receive screening limits
    // ------------------------------------------------------------------
    localparam logic [7:0] T200_RESET = 8'h0A;
    localparam logic [3:0] N2_RESET = 4'h3;
    localparam int CLK_PERIOD_NS = 50;
    localparam int TICK_TIME_NS = 1000000;
    localparam int TICK_CYCLES = TICK_TIME_NS / CLK_PERIOD_NS;
    localparam logic [9:0] MIN_OCTETS = 10'h006;
    localparam logic [2:0] ABORT_ONES = 3'h7;

    // Received frame kinds and supervisory types
    localparam logic [1:0] KIND_I = 2'h0;
    localparam logic [1:0] KIND_S = 2'h1;
    localparam logic [1:0] S_RR = 2'h0;
    localparam logic [1:0] S_RNR = 2'h1;
    localparam logic [1:0] S_REJ = 2'h2;

    typedef enum logic [1:0] {
        ST_NON_AUTO,
        ST_ESTABLISHED,
        ST_RECOVERY
    } lamc_state_e;

endpackage : lamc_pkg

// [core/lamc_link_ctrl.sv]
// Auto-mode LAPD link control: timer, retries, acknowledgement and frame screening
`timescale 1ns/1ps
`default_nettype none
module lamc_link_ctrl
    import lamc_pkg::*;
#(
    parameter int unsigned TICK_CYC = TICK_CYCLES
)
(
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic [7:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [15:0] rdata,
    input wire logic rx_frame_start,
    input wire logic rx_bit_valid,
    input wire logic rx_bit,
    input wire logic rx_frame_end,
    input wire logic [9:0] rx_octets,
    input wire logic rx_flag_bounded,
    input wire logic rx_octet_aligned,
    input wire logic rx_crc_ok,
    input wire logic rx_addr_two,
    input wire logic rx_sapi_ok,
    input wire logic [1:0] rx_kind,
    input wire logic [1:0] rx_s_type,
    input wire logic rx_nr_ack,
    input wire logic rx_nr_bad,
    input wire logic rx_final,
    input wire logic tx_done,
    input wire logic tx_collision,
    input wire logic tx_s_sent,
    output logic tx_send_numbered,
    output logic tx_send_transparent,
    output logic tx_send_poll,
    output logic rx_seq_clear,
    output logic tx_seq_clear,
    output logic rx_frame_accept,
    output logic rx_frame_discard,
    output logic transmit_pool_ready_irq,
    output logic transmit_repeat_irq,
    output logic timer_expiry_irq,
    output logic remote_status_change_irq,
    output logic protocol_error_irq
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    lamc_state_e st, next_st;
    logic mode_auto, next_mode_auto;
    logic timer_mode_select, next_timer_mode_select;
    logic [7:0] t200, next_t200;
    logic [3:0] n2, next_n2;
    logic [3:0] retry_counter, next_retry_counter;
    logic [7:0] tmr_cnt, next_tmr_cnt;
    logic tmr_run, next_tmr_run;
    logic [14:0] presc, next_presc;
    logic wait_for_ack_flag, next_wait_for_ack_flag;
    logic peer_receiver_busy_flag, next_peer_receiver_busy_flag;
    logic supervisory_seen_flag, next_supervisory_seen_flag;
    logic last_transparent, next_last_transparent;
    logic tx_busy, next_tx_busy;
    logic [2:0] ones_cnt, next_ones_cnt;
    logic aborted, next_aborted;
    logic [15:0] next_rdata;
    logic next_send_numbered, next_send_transparent, next_send_poll;
    logic next_rx_seq_clear, next_tx_seq_clear, next_accept, next_discard;
    logic next_xpr, next_xmr, next_tin, next_rsc, next_pce;

    logic tick, expire, frame_ok, rx_ok, cmd_wr, tmr_wr, internal;
    logic [15:0] cmd;

    always_comb
    begin
        tick = (presc == 15'(TICK_CYC - 1));
        expire = tmr_run && tick && (tmr_cnt <= 8'h01);
        cmd_wr = wr && (addr == REG_CMD);
        tmr_wr = wr && (addr == REG_TIMER);
        cmd = cmd_wr ? wdata : 16'h0000;
        internal = mode_auto && timer_mode_select;
        frame_ok = rx_flag_bounded && (rx_octets >= MIN_OCTETS) && rx_octet_aligned
            && rx_crc_ok && rx_addr_two && rx_sapi_ok && !aborted;
        rx_ok = rx_frame_end && frame_ok;
    end

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb
    begin
        next_st = st;
        next_mode_auto = mode_auto;
        next_timer_mode_select = timer_mode_select;
        next_t200 = t200;
        next_n2 = n2;
        next_retry_counter = retry_counter;
        next_tmr_cnt = tmr_cnt;
        next_tmr_run = tmr_run;
        next_presc = tick ? 15'h0000 : presc + 15'h0001;
        next_wait_for_ack_flag = wait_for_ack_flag;
        next_peer_receiver_busy_flag = peer_receiver_busy_flag;
        next_supervisory_seen_flag = supervisory_seen_flag;
        next_last_transparent = last_transparent;
        next_tx_busy = tx_busy;
        next_ones_cnt = ones_cnt;
        next_aborted = aborted;
        next_rdata = 16'h0000;
        next_send_numbered = 1'b0;
        next_send_transparent = 1'b0;
        next_send_poll = 1'b0;
        next_rx_seq_clear = cmd[CMD_RX_RESET_BIT];
        next_tx_seq_clear = cmd[CMD_TX_RESET_BIT];
        next_accept = rx_ok;
        next_discard = rx_frame_end && !frame_ok;
        next_xpr = 1'b0;
        next_xmr = 1'b0;
        next_tin = 1'b0;
        next_rsc = 1'b0;
        next_pce = 1'b0;

        // Register reads, data one cycle later
        if (rd && addr == REG_MODE)
        begin
            next_rdata[MODE_AUTO_BIT] = mode_auto;
            next_rdata[MODE_TMD_BIT] = timer_mode_select;
        end
        else if (rd && addr == REG_TIMER)
        begin
            next_rdata[TIMER_T200_LSB +: 8] = t200;
            next_rdata[TIMER_N2_LSB +: 4] = n2;
        end
        else if (rd && addr == REG_MAIN_STATUS)
        begin
            next_rdata[MAIN_PEER_BUSY_BIT] = peer_receiver_busy_flag;
            next_rdata[MAIN_POOL_FREE_BIT] = !tx_busy;
        end
        else if (rd && addr == REG_AUTO_STATUS)
        begin
            next_rdata[AUTO_RECOVERY_BIT] = (st == ST_RECOVERY);
            next_rdata[AUTO_WFA_BIT] = wait_for_ack_flag;
            next_rdata[AUTO_SUPERVISORY_SEEN_FLAG_BIT] = supervisory_seen_flag;
            next_supervisory_seen_flag = 1'b0;
        end

        if (wr && addr == REG_MODE)
        begin
            next_mode_auto = wdata[MODE_AUTO_BIT];
            next_timer_mode_select = wdata[MODE_TMD_BIT];
        end
        // A write to the timer register stops the timer unless an internal-timer expiry in auto mode restarts it in the same cycle
        if (tmr_wr)
        begin
            next_t200 = wdata[TIMER_T200_LSB +: 8];
            next_n2 = wdata[TIMER_N2_LSB +: 4];
            next_tmr_run = 1'b0;
        end
        else if (tmr_run && tick)
        begin
            next_tmr_cnt = tmr_cnt - 8'h01;
            if (expire)
                next_tmr_run = 1'b0;
        end

        // Abort detection on the receive bit stream
        if (rx_frame_start)
        begin
            next_ones_cnt = 3'h0;
            next_aborted = 1'b0;
        end
        else if (rx_bit_valid)
        begin
            next_ones_cnt = !rx_bit ? 3'h0 : (ones_cnt == ABORT_ONES) ? ones_cnt : ones_cnt + 3'h1;
            if (rx_bit && ones_cnt == ABORT_ONES - 3'h1)
                next_aborted = 1'b1;
        end

        if (tx_s_sent)
            next_supervisory_seen_flag = 1'b1;

        // Transparent send works in every mode
        if (cmd[CMD_TRANSPARENT_BIT] && !tx_busy)
        begin
            next_send_transparent = 1'b1;
            next_last_transparent = 1'b1;
            next_tx_busy = 1'b1;
        end

        if (!mode_auto)
        begin
            next_st = ST_NON_AUTO;
            next_retry_counter = 4'h0;
            next_wait_for_ack_flag = 1'b0;
            // External mode: software starts the timer, expiry is only reported
            if (cmd[CMD_START_TIMER_BIT] && !timer_mode_select)
            begin
                next_tmr_run = 1'b1;
                next_tmr_cnt = t200;
            end
            if (expire)
                next_tin = 1'b1;
            if (tx_done)
            begin
                next_xpr = 1'b1;
                next_tx_busy = 1'b0;
            end
            if (tx_collision)
            begin
                next_xmr = 1'b1;
                next_tx_busy = 1'b0;
            end
        end
        else
        begin
            if (st == ST_NON_AUTO)
                next_st = ST_ESTABLISHED;
            // Numbered send needs the internal timer and a free window
            if (cmd[CMD_NUMBERED_BIT] && internal && !tx_busy && !wait_for_ack_flag
                && st == ST_ESTABLISHED && !peer_receiver_busy_flag)
            begin
                next_send_numbered = 1'b1;
                next_last_transparent = 1'b0;
                next_tx_busy = 1'b1;
                next_wait_for_ack_flag = 1'b1;
                next_tmr_run = 1'b1;
                next_tmr_cnt = t200;
            end
            if (tx_done && (last_transparent || !wait_for_ack_flag))
            begin
                next_xpr = 1'b1;
                next_tx_busy = 1'b0;
            end
            if (tx_collision)
            begin
                next_xmr = 1'b1;
                next_tx_busy = 1'b0;
                if (!last_transparent)
                begin
                    next_wait_for_ack_flag = 1'b0;
                    next_tmr_run = 1'b0;
                    next_st = ST_ESTABLISHED;
                    next_retry_counter = 4'h0;
                end
            end
            if (rx_ok && rx_nr_bad)
                next_pce = 1'b1;
            else if (rx_ok && (rx_kind == KIND_I || rx_kind == KIND_S))
            begin
                if (rx_kind == KIND_S)
                begin
                    next_peer_receiver_busy_flag = (rx_s_type == S_RNR);
                    if ((rx_s_type == S_RNR) != peer_receiver_busy_flag)
                        next_rsc = 1'b1;
                end
                if (rx_kind == KIND_S && rx_s_type == S_REJ && wait_for_ack_flag)
                begin
                    next_xmr = 1'b1;
                    next_tx_busy = 1'b0;
                    next_wait_for_ack_flag = 1'b0;
                    next_tmr_run = 1'b0;
                    next_st = ST_ESTABLISHED;
                    next_retry_counter = 4'h0;
                end
                else
                begin
                    if (rx_nr_ack && wait_for_ack_flag)
                    begin
                        next_xpr = 1'b1;
                        next_tx_busy = 1'b0;
                        next_wait_for_ack_flag = 1'b0;
                        next_tmr_run = 1'b0;
                    end
                    if (st == ST_RECOVERY && rx_final && rx_kind == KIND_S)
                    begin
                        next_st = ST_ESTABLISHED;
                        next_retry_counter = 4'h0;
                        next_tmr_run = 1'b0;
                    end
                end
            end
            // Acknowledgement timer and polling in recovery
            if (expire && internal)
            begin
                if (st == ST_RECOVERY && retry_counter >= n2)
                begin
                    next_tin = 1'b1;
                    next_xpr = wait_for_ack_flag;
                    next_tx_busy = 1'b0;
                end
                else
                begin
                    next_st = ST_RECOVERY;
                    next_send_poll = 1'b1;
                    next_retry_counter = retry_counter + 4'h1;
                    next_tmr_run = 1'b1;
                    next_tmr_cnt = t200;
                end
            end
            if (cmd[CMD_START_TIMER_BIT] && internal)
            begin
                next_st = ST_RECOVERY;
                next_retry_counter = 4'h0;
                next_tmr_run = 1'b1;
                next_tmr_cnt = t200;
            end
        end

        if (cmd[CMD_TX_RESET_BIT])
        begin
            next_tx_busy = 1'b0;
            next_wait_for_ack_flag = 1'b0;
            next_xpr = 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st <= ST_NON_AUTO;
            mode_auto <= 1'b0;
            timer_mode_select <= 1'b0;
            t200 <= T200_RESET;
            n2 <= N2_RESET;
            retry_counter <= 4'h0;
            tmr_cnt <= 8'h00;
            tmr_run <= 1'b0;
            presc <= 15'h0000;
            wait_for_ack_flag <= 1'b0;
            peer_receiver_busy_flag <= 1'b0;
            supervisory_seen_flag <= 1'b0;
            last_transparent <= 1'b0;
            tx_busy <= 1'b0;
            ones_cnt <= 3'h0;
            aborted <= 1'b0;
            rdata <= 16'h0000;
            tx_send_numbered <= 1'b0;
            tx_send_transparent <= 1'b0;
            tx_send_poll <= 1'b0;
            rx_seq_clear <= 1'b0;
            tx_seq_clear <= 1'b0;
            rx_frame_accept <= 1'b0;
            rx_frame_discard <= 1'b0;
            transmit_pool_ready_irq <= 1'b0;
            transmit_repeat_irq <= 1'b0;
            timer_expiry_irq <= 1'b0;
            remote_status_change_irq <= 1'b0;
            protocol_error_irq <= 1'b0;
        end
        else
        begin
            st <= next_st;
            mode_auto <= next_mode_auto;
            timer_mode_select <= next_timer_mode_select;
            t200 <= next_t200;
            n2 <= next_n2;
            retry_counter <= next_retry_counter;
            tmr_cnt <= next_tmr_cnt;
            tmr_run <= next_tmr_run;
            presc <= next_presc;
            wait_for_ack_flag <= next_wait_for_ack_flag;
            peer_receiver_busy_flag <= next_peer_receiver_busy_flag;
            supervisory_seen_flag <= next_supervisory_seen_flag;
            last_transparent <= next_last_transparent;
            tx_busy <= next_tx_busy;
            ones_cnt <= next_ones_cnt;
            aborted <= next_aborted;
            rdata <= next_rdata;
            tx_send_numbered <= next_send_numbered;
            tx_send_transparent <= next_send_transparent;
            tx_send_poll <= next_send_poll;
            rx_seq_clear <= next_rx_seq_clear;
            tx_seq_clear <= next_tx_seq_clear;
            rx_frame_accept <= next_accept;
            rx_frame_discard <= next_discard;
            transmit_pool_ready_irq <= next_xpr;
            transmit_repeat_irq <= next_xmr;
            timer_expiry_irq <= next_tin;
            remote_status_change_irq <= next_rsc;
            protocol_error_irq <= next_pce;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    non_auto_state_a: assert property (!mode_auto |=> st == ST_NON_AUTO)
        else $error("state left non-auto while auto mode off");
    timer_idle_a: assert property (!mode_auto && !timer_mode_select && !tmr_run
        && !cmd[CMD_START_TIMER_BIT] |=> !tmr_run)
        else $error("timer started without command outside auto mode");
    numbered_gate_a: assert property (tx_send_numbered |-> $past(mode_auto)
        && $past(timer_mode_select))
        else $error("numbered frame sent outside auto mode");
    status_gate_a: assert property (remote_status_change_irq || protocol_error_irq
        |-> $past(mode_auto))
        else $error("status change event outside auto mode");
    ack_ready_a: assert property (mode_auto && wait_for_ack_flag && rx_ok && rx_nr_ack
        && !rx_nr_bad && (rx_kind == KIND_I || (rx_kind == KIND_S && rx_s_type != S_REJ))
        |=> transmit_pool_ready_irq && !wait_for_ack_flag)
        else $error("acknowledge did not raise pool ready");
    sent_ready_a: assert property (!mode_auto && tx_done |=> transmit_pool_ready_irq)
        else $error("non-auto frame done without pool ready");
    repeat_state_a: assert property (mode_auto && transmit_repeat_irq && !last_transparent
        && !$past(cmd[CMD_START_TIMER_BIT]) |-> st != ST_RECOVERY)
        else $error("repeat event left device in recovery");
    collision_repeat_a: assert property (!mode_auto && tx_collision |=> transmit_repeat_irq)
        else $error("collision did not raise repeat");
    retry_clear_a: assert property (st == ST_RECOVERY ##1 st == ST_ESTABLISHED
        |-> retry_counter == 4'h0)
        else $error("retry count not cleared on leaving recovery");
    start_timer_a: assert property (internal && cmd[CMD_START_TIMER_BIT]
        |=> st == ST_RECOVERY && retry_counter == 4'h0 && tmr_run)
        else $error("start timer did not enter recovery");
    supervisory_seen_flag_set_a: assert property (tx_s_sent |=> supervisory_seen_flag)
        else $error("supervisory seen flag not set");
    short_frame_a: assert property (rx_frame_end && rx_octets < MIN_OCTETS
        |=> rx_frame_discard && !rx_frame_accept)
        else $error("short frame accepted");
    abort_frame_a: assert property (rx_bit_valid && rx_bit && !rx_frame_start [*7]
        ##1 !rx_frame_start ##1 (rx_frame_end && !rx_frame_start) |=> rx_frame_discard)
        else $error("aborted frame accepted");

endmodule : lamc_link_ctrl
`default_nettype wire

// [bench/lamc_peer_model.sv]
// Behavioural model of the remote link peer
`timescale 1ns/1ps
`default_nettype none
module lamc_peer_model
    import lamc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic [1:0] mode,
    input wire logic tx_send_numbered,
    input wire logic tx_send_transparent,
    input wire logic tx_send_poll,
    output var logic tx_done,
    output var logic p_end,
    output var logic [1:0] rx_kind,
    output var logic [1:0] rx_s_type,
    output var logic rx_nr_ack,
    output var logic rx_final
);
    // Mode 0 silent, 1 acknowledges, 2 rejects, 3 acknowledges with final bit
    logic [2:0] dn, an;
    always @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            {dn, an, tx_done, p_end, rx_kind, rx_s_type, rx_nr_ack, rx_final} <= '0;
        else
        begin
            tx_done <= dn == 3'h1;
            p_end <= an == 3'h1;
            dn <= (tx_send_numbered || tx_send_transparent) ? 3'h3 : dn - 3'(dn != 3'h0);
            an <= ((tx_send_numbered || tx_send_poll) && mode != 2'h0) ? 3'h5 : an - 3'(an != 3'h0);
            // Kind and type fields toggle while no frame is offered
            rx_kind <= an == 3'h1 ? KIND_S : ~rx_kind;
            rx_s_type <= an != 3'h1 ? ~rx_s_type : (mode == 2'h2 ? S_REJ : S_RR);
            rx_nr_ack <= an == 3'h1 && mode != 2'h2;
            rx_final <= an == 3'h1 && mode == 2'h3;
        end
    end
endmodule : lamc_peer_model
`default_nettype wire

// [bench/lamc_link_ctrl_test.sv]
// Self-checking bench for the auto-mode link control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin n_mismatch++; \
    $display("ERROR %s exp %h got %h", n, e, s); end end
module lamc_link_ctrl_test;
    import lamc_pkg::*;
    logic ref_clk = 0, arst_n = 0, wr = 0, rd = 0, fs = 0, bv = 0, bt = 0, fe = 0;
    logic col = 0, ss = 0, hit, done, pend, ack, fin;
    logic [4:0] ok = 5'h1F;
    logic [7:0] addr = 8'h00;
    logic [15:0] wdata = 16'h0000, rdata, rv;
    logic [9:0] oct = 10'h010;
    logic [1:0] pm = 2'h0, kind, styp;
    logic [11:0] o;
    int n_mismatch = 0, checks = 0, cyc = 0;
    always #25 ref_clk = ~ref_clk;
    lamc_link_ctrl #(.TICK_CYC(4)) lamc_link_ctrl_i (
        .ref_clk(ref_clk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .rx_frame_start(fs), .rx_bit_valid(bv), .rx_bit(bt),
        .rx_frame_end(fe | pend), .rx_octets(oct), .rx_flag_bounded(ok[0]),
        .rx_octet_aligned(ok[1]), .rx_crc_ok(ok[2]), .rx_addr_two(ok[3]), .rx_sapi_ok(ok[4]),
        .rx_kind(kind), .rx_s_type(styp), .rx_nr_ack(ack), .rx_nr_bad(1'b0), .rx_final(fin),
        .tx_done(done), .tx_collision(col), .tx_s_sent(ss), .tx_send_numbered(o[0]),
        .tx_send_transparent(o[1]), .tx_send_poll(o[2]), .rx_seq_clear(o[3]),
        .tx_seq_clear(o[4]), .rx_frame_accept(o[5]), .rx_frame_discard(o[6]),
        .transmit_pool_ready_irq(o[7]), .transmit_repeat_irq(o[8]), .timer_expiry_irq(o[9]),
        .remote_status_change_irq(o[10]), .protocol_error_irq(o[11]));
    lamc_peer_model lamc_peer_model_i (
        .ref_clk(ref_clk), .arst_n(arst_n), .mode(pm), .tx_send_numbered(o[0]),
        .tx_send_transparent(o[1]), .tx_send_poll(o[2]), .tx_done(done), .p_end(pend),
        .rx_kind(kind), .rx_s_type(styp), .rx_nr_ack(ack), .rx_final(fin));
    task automatic bw(input logic [7:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge ref_clk);
        wr <= 1'b0;
    endtask : bw
    task automatic br(input logic [7:0] a);
        @(posedge ref_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge ref_clk);
        rd <= 1'b0;
        #1 rv = rdata;
    endtask : br
    // Watches one output pulse for up to n cycles, stops early once seen
    task automatic wp(input int b, input int n);
        #1 hit = o[b];
        repeat (n) if (!hit) @(posedge ref_clk) #1 hit = o[b];
    endtask : wp
    task automatic frm(input int ones);
        @(posedge ref_clk) fs <= 1'b1;
        @(posedge ref_clk) fs <= 1'b0;
        bv <= 1'b1;
        bt <= (ones > 0);
        repeat (ones) @(posedge ref_clk);
        if (ones > 0)
            bt <= 1'b0;
        @(posedge ref_clk) bv <= 1'b0;
        fe <= 1'b1;
        @(posedge ref_clk) fe <= 1'b0;
        wp(6, 1);
    endtask : frm
    function automatic logic bad(input int ones);
        return !(&ok && oct >= MIN_OCTETS) || ones >= ABORT_ONES;
    endfunction : bad
    task automatic final_report;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : final_report
    always @(posedge ref_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            n_mismatch++;
            final_report;
        end
    end
    initial
    begin
        void'($urandom(32'h5e84));
        repeat (10) @(posedge ref_clk);
        arst_n <= 1'b1;
        br(REG_TIMER);
        `CHK("timer", {4'h0, N2_RESET, T200_RESET}, rv)
        br(8'h14);
        `CHK("unmapped", 16'h0000, rv)
        for (int i = 0; i < 24; i++)
        begin
            ok <= i < 4 ? 5'h1F : 5'($urandom);
            oct <= 10'($urandom % 9);
            frm(i % 9);
            `CHK("discard", bad(i % 9), hit)
        end
        ok <= 5'h1F;
        oct <= 10'h010;
        bw(REG_CMD, 16'h0001);
        wp(0, 6);
        `CHK("non-auto send", 1'b0, hit)
        $display("test screening done");
        bw(REG_CMD, 16'h0002);
        wp(1, 2);
        `CHK("transparent", 1'b1, hit)
        wp(7, 10);
        `CHK("sent", 1'b1, hit)
        bw(REG_CMD, 16'h0002);
        col <= 1'b1;
        @(posedge ref_clk) col <= 1'b0;
        wp(8, 4);
        `CHK("collision", 1'b1, hit)
        repeat (8) @(posedge ref_clk);
        $display("test transparent done");
        bw(REG_MODE, 16'h0003);
        bw(REG_TIMER, 16'h0104);
        br(REG_TIMER);
        `CHK("timer set", {4'h0, 4'h1, 8'h04}, rv)
        br(REG_MAIN_STATUS);
        `CHK("peer free", 1'b0, rv[MAIN_PEER_BUSY_BIT])
        pm <= 2'h1;
        bw(REG_CMD, 16'h0001);
        wp(0, 2);
        `CHK("numbered", 1'b1, hit)
        wp(7, 12);
        `CHK("acked", 1'b1, hit)
        pm <= 2'h2;
        bw(REG_CMD, 16'h0001);
        wp(8, 12);
        `CHK("rejected", 1'b1, hit)
        br(REG_AUTO_STATUS);
        `CHK("state 7", 1'b0, rv[AUTO_RECOVERY_BIT])
        pm <= 2'h0;
        bw(REG_CMD, 16'h0001);
        wp(2, 20);
        `CHK("poll", 1'b1, hit)
        wp(9, 40);
        `CHK("expiry", 1'b1, hit)
        $display("test numbered done");
        pm <= 2'h3;
        bw(REG_CMD, 16'h0004);
        br(REG_AUTO_STATUS);
        `CHK("start timer", 1'b1, rv[AUTO_RECOVERY_BIT])
        wp(2, 20);
        repeat (10) @(posedge ref_clk);
        br(REG_AUTO_STATUS);
        `CHK("recovered", 1'b0, rv[AUTO_RECOVERY_BIT])
        ss <= 1'b1;
        @(posedge ref_clk) ss <= 1'b0;
        br(REG_AUTO_STATUS);
        `CHK("s seen", 1'b1, rv[AUTO_SUPERVISORY_SEEN_FLAG_BIT])
        br(REG_AUTO_STATUS);
        `CHK("s seen cleared", 1'b0, rv[AUTO_SUPERVISORY_SEEN_FLAG_BIT])
        $display("test recovery done");
        br(REG_AUTO_STATUS);
        `CHK("wfa saved", 1'b0, rv[AUTO_WFA_BIT])
        bw(REG_MODE, 16'h0000);
        bw(REG_TIMER, 16'h0104);
        br(REG_MODE);
        `CHK("non-auto mode", 16'h0000, rv)
        repeat (8) @(posedge ref_clk);
        bw(REG_CMD, 16'h0018);
        #1;
        `CHK("rx seq clear", 1'b1, o[3])
        `CHK("tx seq clear", 1'b1, o[4])
        $display("test leave auto done");
        final_report;
    end
endmodule : lamc_link_ctrl_test
`default_nettype wire
